// *** common/mcsps_pkg.sv ***
// Purpose: Shared constants for the main clock select, prescale and start-up block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes:   Oscillator sources arrive as one-cycle tick enables on the 20 MHz clock.
`default_nettype none
package mcsps_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ             = 20_000_000;
    localparam int          LF_OSC_HZ          = 128_000;
    localparam int          RESET_DELAY_MS     = 64;
    localparam int          RESET_DELAY_TICKS  = RESET_DELAY_MS * (LF_OSC_HZ / 1000);
    localparam logic [2:0]  OSC_START_CYCLES   = 3'h6;
    localparam logic [4:0]  CONFIG_CYCLES      = 5'h15;
    localparam logic [2:0]  WAKE_START_CYCLES  = 3'h6;
    localparam logic [2:0]  UNLOCK_CYCLES      = 3'h4;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CHANGE_PROTECT = 8'h00;
    localparam logic [7:0]  ADDR_MAIN_SETTINGS  = 8'h04;
    localparam logic [7:0]  ADDR_PRESCALE       = 8'h08;
    localparam logic [7:0]  ADDR_OSC_TRIM       = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS         = 8'h10;
    // Signature value is arbitrary.
    localparam logic [7:0]  CHANGE_SIGNATURE    = 8'h5a;
    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  SRC_CAL8            = 2'h0;
    localparam logic [1:0]  SRC_LF128           = 2'h1;
    localparam logic [1:0]  SRC_EXT             = 2'h2;
    localparam logic [1:0]  SRC_RESERVED        = 2'h3;
    localparam logic [3:0]  PRESCALE_RESET      = 4'h3;
    localparam logic [3:0]  PRESCALE_MAX_CODE   = 4'h8;
    localparam logic [7:0]  TRIM_RESET          = 8'h00;
    localparam int          STAT_SRC_LSB        = 0;
    localparam int          STAT_PS_LSB         = 4;
    localparam int          STAT_STATE_LSB      = 8;
    localparam int          STAT_PEND_BIT       = 11;
    localparam int          STAT_UNLOCK_BIT     = 12;
    // ------------------------------------------------------------------
    // Sleep modes and start-up states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLP_IDLE      = 2'b00,
        SLP_NOISE_RED = 2'b01,
        SLP_STANDBY   = 2'b10,
        SLP_POWERDOWN = 2'b11
    } mcsps_sleep_e;
    typedef enum logic [2:0] {
        ST_HOLD   = 3'b000,
        ST_RDELAY = 3'b001,
        ST_OSC    = 3'b010,
        ST_CONFIG = 3'b011,
        ST_RUN    = 3'b100,
        ST_SLEEP  = 3'b101,
        ST_WAKE   = 3'b110
    } mcsps_state_e;
endpackage
`default_nettype wire

// *** design/mcsps_top.sv ***
// Purpose: Main clock source select, system prescaler, domain gating and start-up.
// Assumes: Source ticks, reset request and sleep controls are synchronous to clk.
// Notes:   Every derived clock is a one-cycle enable; no clock is gated directly.
//
// Operation
// - Select field 0b00 picks the calibrated 8 MHz oscillator as main clock.
// - Select field 0b10 picks the external clock input as main clock.
// - Select field 0b01 picks the 128 kHz oscillator as main clock.
// - Main source may change at run time without any main clock glitch.
// - After reset the calibrated oscillator is selected and divided by 8.
// - System clock comes from main clock through the prescaler, feeding core and peripherals.
// - Prescale change is glitch-free; no period faster than old and new.
// - New frequency active within T1+T2 to T1+2*T2, with two edges.
// - Prescaler counts at main clock rate; its state is not readable.
// - Internal reset asserts at once and holds until the start-up completes.
// - First step counts a 64 ms delay on the 128 kHz oscillator, unconditionally.
// - Second step waits 6 calibrated oscillator cycles.
// - Last step spends 21 system clock cycles loading configuration.
// - Factory calibration byte loads into the trim register during reset.
// - Power-down wake-up counts only 6 main clock cycles.
// - Idle, noise reduction and standby wake-ups add no start-up delay.
// - Watchdog and reset time-out keep running from the 128 kHz oscillator.
// - Core clock drives register file, system registers and SRAM; gating halts core.
// - Peripheral clock drives I/O; some external interrupts detected while it is gated.
// - Nonvolatile controller clock is enabled and gated with the core clock, except in the configuration step where it runs alone.
// - Converter clock may run while core and peripheral clocks are gated.
// - Prescale codes 0 to 8 divide by 1 to 256; reset value is 3.
// - Source select writes only accepted within four cycles after the signature.
//
// Added by the designer: the APB interface to the registers and the address map.
`default_nettype none
module mcsps_top
    import mcsps_pkg::*;
#(
    parameter int RESET_DELAY = mcsps_pkg::RESET_DELAY_TICKS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Oscillator and external clock ticks
    input  wire logic        osc8_tick,
    input  wire logic        osc128_tick,
    input  wire logic        ext_clock_input,
    // Reset sources and calibration
    input  wire logic        reset_request,
    input  wire logic [7:0]  calib_byte,
    // Sleep control
    input  wire logic        sleep_req,
    input  wire logic [1:0]  sleep_mode,
    input  wire logic        wake_event,
    input  wire logic        ext_irq_level,
    // Derived enables and status
    output logic             main_clock_en,
    output logic             sys_clock_en,
    output logic             core_clock,
    output logic             periph_clock,
    output logic             nonvolatile_ctrl_clock,
    output logic             converter_clock,
    output logic             watchdog_clock_en,
    output logic             async_irq_wake,
    output logic             main_osc_enable,
    output logic             internal_reset,
    output logic [7:0]       osc_trim
);
    import mcsps_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (RESET_DELAY < 1 || RESET_DELAY > 65535) begin : g_bad_delay
        $error("RESET_DELAY must lie between 1 and 65535");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    mcsps_state_e state;
    mcsps_state_e next_state;
    logic [15:0]  delay_cnt;
    logic [4:0]   step_cnt;
    logic [1:0]   active_src;
    logic [1:0]   pend_src;
    logic [3:0]   active_ps;
    logic [3:0]   pend_ps;
    logic [7:0]   div_cnt;
    logic [2:0]   unlock_cnt;
    logic [1:0]   slp_mode;
    logic         rd_done;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire       access     = psel & penable;
    wire       bus_done   = access & rd_done;
    wire       wr_ok      = bus_done & pwrite & ~internal_reset;
    wire       hit_ccp    = (paddr == ADDR_CHANGE_PROTECT);
    wire       hit_main   = (paddr == ADDR_MAIN_SETTINGS);
    wire       hit_ps     = (paddr == ADDR_PRESCALE);
    wire       hit_trim   = (paddr == ADDR_OSC_TRIM);
    wire       hit_stat   = (paddr == ADDR_STATUS);
    wire       mapped     = hit_ccp | hit_main | hit_ps | hit_trim | hit_stat;
    wire       unlocked   = (unlock_cnt != 3'h0);
    wire       sig_write  = wr_ok & hit_ccp & (pwdata[7:0] == CHANGE_SIGNATURE);
    wire       src_write  = wr_ok & hit_main & unlocked
                            & (pwdata[1:0] != SRC_RESERVED);
    wire       ps_write   = wr_ok & hit_ps & unlocked
                            & (pwdata[3:0] <= PRESCALE_MAX_CODE);
    wire       trim_write = wr_ok & hit_trim;

    assign pready  = bus_done;
    assign pslverr = bus_done & ~mapped;

    // ------------------------------------------------------------------
    // Source selection and prescaler
    // ------------------------------------------------------------------
    function automatic logic pick_tick(input logic [1:0] sel, input logic t8,
                                       input logic t128, input logic tex);
        case (sel)
            SRC_CAL8:  pick_tick = t8;
            SRC_LF128: pick_tick = t128;
            SRC_EXT:   pick_tick = tex;
            default:   pick_tick = 1'b0;
        endcase
    endfunction

    // The source changes only on a tick of the old source, so a main period
    // is never cut short; the first new period then ends on a new tick.
    wire       old_tick   = pick_tick(active_src, osc8_tick, osc128_tick, ext_clock_input);
    wire       src_swap   = old_tick & (pend_src != active_src);
    assign main_clock_en  = old_tick;

    // Divide limit per code: the count wraps after 2**code main ticks.
    wire [7:0] div_last   = 8'(({1'b0, 8'h01} << active_ps) - 9'h001);
    wire       sys_tick   = main_clock_en & (div_cnt == div_last);
    assign sys_clock_en   = sys_tick;

    // ------------------------------------------------------------------
    // Start-up sequencing
    // ------------------------------------------------------------------
    wire       run_state  = (state == ST_RUN);
    wire       in_sleep   = (state == ST_SLEEP);
    wire       delay_end  = osc128_tick & (delay_cnt == 16'(RESET_DELAY - 1));
    wire       osc_end    = osc8_tick & (step_cnt == 5'(OSC_START_CYCLES - 3'h1));
    wire       cfg_end    = sys_tick & (step_cnt == CONFIG_CYCLES - 5'h01);
    wire       wake_end   = main_clock_en & (step_cnt == 5'(WAKE_START_CYCLES - 3'h1));

    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD:   next_state = ST_RDELAY;
            ST_RDELAY: if (delay_end) begin
                next_state = ST_OSC;
            end
            ST_OSC:    if (osc_end) begin
                next_state = ST_CONFIG;
            end
            ST_CONFIG: if (cfg_end) begin
                next_state = ST_RUN;
            end
            ST_RUN:    if (sleep_req) begin
                next_state = ST_SLEEP;
            end
            ST_SLEEP:  if (wake_event) begin
                next_state = (slp_mode == SLP_POWERDOWN) ? ST_WAKE : ST_RUN;
            end
            ST_WAKE:   if (wake_end) begin
                next_state = ST_RUN;
            end
            default:   next_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || reset_request) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // The delay counts on the slow oscillator only; supply level is never sampled.
    always_ff @(posedge clk) begin
        if (rst || reset_request || state != ST_RDELAY) begin
            delay_cnt <= 16'h0000;
        end else if (osc128_tick) begin
            delay_cnt <= delay_cnt + 16'h0001;
        end
    end

    wire step_inc = (state == ST_OSC && osc8_tick)
                  | (state == ST_CONFIG && sys_tick)
                  | (state == ST_WAKE && main_clock_en);

    always_ff @(posedge clk) begin
        if (rst || reset_request || state != next_state) begin
            step_cnt <= 5'h00;
        end else if (step_inc) begin
            step_cnt <= step_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            slp_mode <= SLP_IDLE;
        end else if (run_state && sleep_req) begin
            slp_mode <= sleep_mode;
        end
    end

    // Reset is combinational so that a reset source takes effect in its own cycle.
    assign internal_reset = rst | reset_request | (state < ST_RUN);

    // ------------------------------------------------------------------
    // Clock configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || reset_request) begin
            active_src <= SRC_CAL8;
            pend_src   <= SRC_CAL8;
        end else begin
            if (src_write) begin
                pend_src <= pwdata[1:0];
            end
            if (src_swap) begin
                active_src <= pend_src;
            end
        end
    end

    // A new division starts only at a system clock boundary: the old period
    // completes (T1) and the new count starts from zero (T2), so no shorter
    // period than either setting can appear.
    always_ff @(posedge clk) begin
        if (rst || reset_request) begin
            active_ps <= PRESCALE_RESET;
            pend_ps   <= PRESCALE_RESET;
        end else begin
            if (ps_write) begin
                pend_ps <= pwdata[3:0];
            end
            if (sys_tick) begin
                active_ps <= pend_ps;
            end
        end
    end

    // Counter advances on every main tick and is kept out of the register map.
    always_ff @(posedge clk) begin
        if (rst || reset_request || src_swap || sys_tick) begin
            div_cnt <= 8'h00;
        end else if (main_clock_en) begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Window length is counted in system clock cycles, one per instruction.
    always_ff @(posedge clk) begin
        if (rst || reset_request) begin
            unlock_cnt <= 3'h0;
        end else if (sig_write) begin
            unlock_cnt <= UNLOCK_CYCLES;
        end else if (src_write || ps_write) begin
            unlock_cnt <= 3'h0;
        end else if (unlocked && sys_tick) begin
            unlock_cnt <= unlock_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            osc_trim <= TRIM_RESET;
        end else if (state == ST_CONFIG) begin
            osc_trim <= calib_byte;
        end else if (trim_write) begin
            osc_trim <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Clock domain gating
    // ------------------------------------------------------------------
    wire core_on   = run_state;
    wire nvm_on    = run_state | (state == ST_CONFIG);
    wire periph_on = run_state | (in_sleep & (slp_mode == SLP_IDLE));
    wire conv_on   = periph_on | (in_sleep & (slp_mode == SLP_NOISE_RED));

    assign core_clock             = sys_tick & core_on;
    assign nonvolatile_ctrl_clock = sys_tick & nvm_on;
    assign periph_clock           = sys_tick & periph_on;
    assign converter_clock        = sys_tick & conv_on;
    assign watchdog_clock_en      = osc128_tick;
    assign async_irq_wake         = ext_irq_level & in_sleep;
    assign main_osc_enable        = ~(in_sleep & (slp_mode == SLP_POWERDOWN));

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [31:0] stat_word = (32'(active_src) << STAT_SRC_LSB)
                          | (32'(active_ps) << STAT_PS_LSB)
                          | (32'(state) << STAT_STATE_LSB)
                          | (32'((pend_src != active_src) | (pend_ps != active_ps))
                             << STAT_PEND_BIT)
                          | (32'(unlocked) << STAT_UNLOCK_BIT);
    wire [31:0] rd_mux    = hit_main ? {30'h0, pend_src}
                          : hit_ps   ? {28'h0, pend_ps}
                          : hit_trim ? {24'h0, osc_trim}
                          : hit_stat ? stat_word
                          : 32'h0000_0000;

    // Each access phase takes two cycles so read data leaves a flip-flop.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_done <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            rd_done <= access & ~rd_done;
            if (access && !rd_done) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/mcsps_monitor.sv ***
// Purpose: Concurrent checks on the ports of the clock select and start-up block.
// Assumes: All derived clocks are one-cycle enables sampled on the rising clk edge.
// Notes:   The prescale check runs only during start-up, where the divider is fixed.
`default_nettype none
module mcsps_monitor
    import mcsps_pkg::*;
#(
    parameter int RESET_DELAY = 4
) (
    // Clock, reset and source ticks
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       osc8_tick,
    input wire logic       osc128_tick,
    input wire logic       ext_clock_input,
    // Controls
    input wire logic       reset_request,
    input wire logic       sleep_req,
    input wire logic [1:0] sleep_mode,
    input wire logic       ext_irq_level,
    input wire logic       pready,
    input wire logic       pslverr,
    // Derived enables
    input wire logic       main_clock_en,
    input wire logic       sys_clock_en,
    input wire logic       core_clock,
    input wire logic       nonvolatile_ctrl_clock,
    input wire logic       converter_clock,
    input wire logic       watchdog_clock_en,
    input wire logic       async_irq_wake,
    input wire logic       main_osc_enable,
    input wire logic       internal_reset
);
    // ------------------------------------------------------------------
    // Main ticks between system ticks
    // ------------------------------------------------------------------
    logic [8:0] main_cnt;
    logic       seen_sys;
    always_ff @(posedge clk) begin
        if (rst || reset_request) begin
            main_cnt <= 9'h000;
            seen_sys <= 1'b0;
        end else if (sys_clock_en) begin
            main_cnt <= 9'h000;
            seen_sys <= 1'b1;
        end else if (main_clock_en) begin
            main_cnt <= main_cnt + 9'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    wdog_src_a: assert property (watchdog_clock_en == osc128_tick)
        else $error("watchdog enable differs from slow tick");
    sys_main_a: assert property (sys_clock_en |-> main_clock_en)
        else $error("system tick without main tick");
    core_gate_a: assert property (core_clock |-> sys_clock_en)
        else $error("core tick without system tick");
    conv_gate_a: assert property (converter_clock |-> sys_clock_en)
        else $error("converter tick without system tick");
    nvm_core_a: assert property (!internal_reset |-> nonvolatile_ctrl_clock == core_clock)
        else $error("nonvolatile tick differs from core tick");
    reset_hold_a: assert property (reset_request |-> internal_reset ##1 internal_reset)
        else $error("internal reset not held for reset source");
    main_src_a: assert property (main_clock_en |-> osc8_tick || osc128_tick || ext_clock_input)
        else $error("main tick without any source tick");
    cfg_div8_a: assert property (internal_reset && !reset_request && seen_sys
        && sys_clock_en |-> main_cnt == 9'h007)
        else $error("start-up system tick not one in eight");
    light_sleep_a: assert property (sleep_req && main_osc_enable
        && sleep_mode != SLP_POWERDOWN |=> main_osc_enable)
        else $error("oscillator stopped in light sleep");
    irq_wake_a: assert property (async_irq_wake |-> ext_irq_level)
        else $error("wake flag without interrupt level");
    cover property (sys_clock_en && !internal_reset);
    cover property (pready && pslverr);
    cover property (async_irq_wake);
endmodule
bind mcsps_top mcsps_monitor #(.RESET_DELAY(RESET_DELAY)) mon_u (
    .clk(clk), .rst(rst), .osc8_tick(osc8_tick), .osc128_tick(osc128_tick),
    .ext_clock_input(ext_clock_input), .reset_request(reset_request), .sleep_req(sleep_req),
    .sleep_mode(sleep_mode), .ext_irq_level(ext_irq_level), .pready(pready), .pslverr(pslverr),
    .main_clock_en(main_clock_en), .sys_clock_en(sys_clock_en), .core_clock(core_clock),
    .nonvolatile_ctrl_clock(nonvolatile_ctrl_clock), .converter_clock(converter_clock),
    .watchdog_clock_en(watchdog_clock_en), .async_irq_wake(async_irq_wake),
    .main_osc_enable(main_osc_enable), .internal_reset(internal_reset));
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Directed bench for clock select, prescale, sleep and start-up.
// Assumes: Source ticks are modelled as fixed-rate pulses on the 20 MHz clock.
// Notes:   The reset delay is shortened to 4 slow ticks to keep the run brief.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mcsps_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, osc_trim, calib_byte = 8'ha7;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        osc8_tick = 1'b0, osc128_tick = 1'b0, ext_clock_input = 1'b0, err;
    logic        reset_request = 1'b0, sleep_req = 1'b0, wake_event = 1'b0, ext_irq_level = 1'b0;
    logic [1:0]  sleep_mode = 2'h0;
    logic        pready, pslverr, main_clock_en, sys_clock_en, core_clock, periph_clock;
    logic        nonvolatile_ctrl_clock, converter_clock, watchdog_clock_en, async_irq_wake;
    logic        main_osc_enable, internal_reset;
    int          n_fail = 0, n_compared = 0, tc = 0, cyc = 0, g, k, cv;
    localparam int SPACE [3] = '{3, 40, 5};
    mcsps_top #(.RESET_DELAY(4)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .osc8_tick(osc8_tick), .osc128_tick(osc128_tick), .ext_clock_input(ext_clock_input),
        .reset_request(reset_request), .calib_byte(calib_byte), .sleep_req(sleep_req),
        .sleep_mode(sleep_mode), .wake_event(wake_event), .ext_irq_level(ext_irq_level),
        .main_clock_en(main_clock_en), .sys_clock_en(sys_clock_en), .core_clock(core_clock),
        .periph_clock(periph_clock), .nonvolatile_ctrl_clock(nonvolatile_ctrl_clock),
        .converter_clock(converter_clock), .watchdog_clock_en(watchdog_clock_en),
        .async_irq_wake(async_irq_wake), .main_osc_enable(main_osc_enable),
        .internal_reset(internal_reset), .osc_trim(osc_trim));
    initial begin
        forever #25 clk = ~clk;
    end
    // Source rates in clk cycles: fast 3, slow 40, external 5.
    always @(posedge clk) begin
        tc <= tc + 1;
        osc8_tick <= (tc % 3 == 0);
        osc128_tick <= (tc % 40 == 0);
        ext_clock_input <= (tc % 5 == 0);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            stop_test();
        end
    end
    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask
    task automatic unlock_wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, ADDR_CHANGE_PROTECT, {24'h0, CHANGE_SIGNATURE});
        apb(1'b1, a, d);
    endtask
    // Time from one system tick to the next, in clk cycles.
    task automatic sysgap();
        int n;
        n = 0;
        do @(negedge clk); while (sys_clock_en !== 1'b1 && n++ < 2000);
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while (sys_clock_en !== 1'b1 && g < 2000);
    endtask
    task automatic wait_run();
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (internal_reset !== 1'b0);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_run();
        chk(32'(k >= 600 && k <= 720), 32'h1);
        chk({24'h0, osc_trim}, {24'h0, calib_byte});
        rd(ADDR_MAIN_SETTINGS, 32'h0);
        rd(ADDR_PRESCALE, 32'h3);
        sysgap();
        chk(g, 32'd24);
        apb(1'b1, ADDR_PRESCALE, 32'h5);
        rd(ADDR_PRESCALE, 32'h3);
        unlock_wr(ADDR_PRESCALE, 32'h9);
        rd(ADDR_PRESCALE, 32'h3);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int c = 8; c >= 0; c--) begin
            unlock_wr(ADDR_PRESCALE, 32'(c));
            sysgap();
            sysgap();
            chk(g, 32'(3 << c));
            rd(ADDR_PRESCALE, 32'(c));
        end
        for (int i = 1; i < 4; i++) begin
            unlock_wr(ADDR_MAIN_SETTINGS, 32'(i % 3));
            sysgap();
            sysgap();
            chk(g, SPACE[i % 3]);
            if (i == 2) begin
                unlock_wr(ADDR_MAIN_SETTINGS, 32'h3);
                rd(ADDR_MAIN_SETTINGS, 32'h2);
            end
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            sleep_req <= 1'b1;
            sleep_mode <= (m == 1) ? SLP_POWERDOWN : (m == 2) ? SLP_NOISE_RED : SLP_IDLE;
            ext_irq_level <= 1'b1;
            @(posedge clk);
            sleep_req <= 1'b0;
            g = 0;
            k = 0;
            cv = 0;
            repeat (60) begin
                @(negedge clk);
                g += (core_clock === 1'b1);
                k += (periph_clock === 1'b1);
                cv += (converter_clock === 1'b1);
            end
            chk(32'(g), 32'h0);
            chk(32'(k > 0), 32'(m == 0));
            chk(32'(cv > 0), 32'(m != 1));
            chk({30'h0, main_osc_enable, async_irq_wake}, {30'h0, m != 1, 1'b1});
            @(posedge clk);
            wake_event <= 1'b1;
            ext_irq_level <= 1'b0;
            @(posedge clk);
            wake_event <= 1'b0;
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (core_clock !== 1'b1 && k < 100);
            chk(32'(m == 1 ? (k >= 15 && k <= 24) : (k <= 6)), 32'h1);
        end
        apb(1'b1, ADDR_OSC_TRIM, 32'h3c);
        rd(ADDR_OSC_TRIM, 32'h3c);
        @(posedge clk);
        reset_request <= 1'b1;
        @(negedge clk);
        chk({31'h0, internal_reset}, 32'h1);
        repeat (3) @(posedge clk);
        reset_request <= 1'b0;
        wait_run();
        rd(ADDR_PRESCALE, 32'h3);
        rd(ADDR_MAIN_SETTINGS, 32'h0);
        rd(ADDR_OSC_TRIM, {24'h0, calib_byte});
        stop_test();
    end
endmodule
`default_nettype wire
